// ==== logic/ppm_defines.svh ====
// Offsets, window limits and reset values of the packed process image map
// Included by the package user files; definitions only
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
`define PPM_IN_BASE   16'h0000
`define PPM_IN_LAST   16'h01ff
`define PPM_OUT_BASE  16'h0800
`define PPM_OUT_LAST  16'h09ff
`define PPM_OFS_BASE  16'h2b00
`define PPM_OFS_LAST  16'h2b7f
`define PPM_WIN_REGS  512
`define PPM_OFS_NONE  16'hffff
`define PPM_OFS_HI_BIT 15
`define PPM_RDATA_RST 16'h0000
`define PPM_BYTE_RST  8'h00
`endif

// ==== logic/ppm_pkg.sv ====
// Types shared by the packed process image map
// Assumes nothing from ppm_defines.svh; class and state codes are set here
`default_nettype none
package ppm_pkg;
    // Module class fitted in a slot; sizes follow from the class
    typedef enum logic [3:0] {
        PPM_CLS_NONE  = 4'h0,
        PPM_CLS_DI8   = 4'h1,
        PPM_CLS_DI16  = 4'h2,
        PPM_CLS_DITS  = 4'h3,
        PPM_CLS_DO8   = 4'h4,
        PPM_CLS_DO16  = 4'h5,
        PPM_CLS_AI4   = 4'h6,
        PPM_CLS_AI8   = 4'h7,
        PPM_CLS_AO4   = 4'h8,
        PPM_CLS_CNT1  = 4'h9,
        PPM_CLS_CNT2  = 4'ha,
        PPM_CLS_FREQ  = 4'hb,
        PPM_CLS_PWM   = 4'hc,
        PPM_CLS_SAFE  = 4'hd
    } ppm_class_t;

    typedef enum logic [1:0] {
        PPM_ST_WALK = 2'b00,
        PPM_ST_DONE = 2'b01
    } ppm_state_t;
endpackage
`default_nettype wire

// ==== logic/ppm_image_ram.sv ====
// Process image memory, byte-writable port A, read-only port B
// Assumes a single clock; read data registered, one cycle after enable
`default_nettype none
module ppm_image_ram
    import ppm_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int WIDTH = 16
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       a_en_in,
    input  wire logic [WIDTH/8-1:0]         a_we_in,
    input  wire logic [$clog2(DEPTH)-1:0]   a_addr_in,
    input  wire logic [WIDTH-1:0]           a_wdata_in,
    output logic      [WIDTH-1:0]           a_rdata_out,
    input  wire logic                       b_en_in,
    input  wire logic [$clog2(DEPTH)-1:0]   b_addr_in,
    output logic      [WIDTH-1:0]           b_rdata_out
);
    localparam int LANES = WIDTH / 8;

    if (WIDTH % 8 != 0 || DEPTH < 2) begin : g_bad
        $error("ppm_image_ram: WIDTH must be whole bytes and DEPTH at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Contents are not reset; the map masks unbacked bytes on read
    always_ff @(posedge ref_clk_in) begin
        for (int l = 0; l < LANES; l++) begin
            if (a_en_in && a_we_in[l]) begin
                mem[a_addr_in][l*8 +: 8] <= a_wdata_in[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_rdata_out <= '0;
            b_rdata_out <= '0;
        end else begin
            if (a_en_in) begin
                a_rdata_out <= mem[a_addr_in];
            end
            if (b_en_in) begin
                b_rdata_out <= mem[b_addr_in];
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/ppm_process_image_map.sv ====
// Packed process image map: input and output windows plus module offset table
// Assumes the master port and the backplane port are logic on ref_clk_in
`default_nettype none
`include "ppm_defines.svh"
module ppm_process_image_map
    import ppm_pkg::*;
#(
    parameter int SLOTS = 64
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   cfg_load_in,
    input  wire logic [SLOTS*4-1:0]     cfg_class_in,
    output logic                        map_busy_out,
    input  wire logic                   reg_req_in,
    input  wire logic                   reg_we_in,
    input  wire logic [15:0]            reg_addr_in,
    input  wire logic [15:0]            reg_wdata_in,
    output logic      [15:0]            reg_rdata_out,
    output logic                        reg_ack_out,
    output logic                        reg_err_out,
    input  wire logic                   io_wr_in,
    input  wire logic [$clog2(SLOTS)-1:0] io_wr_slot_in,
    input  wire logic [7:0]             io_wr_byte_in,
    input  wire logic [7:0]             io_wr_data_in,
    input  wire logic                   io_rd_in,
    input  wire logic [$clog2(SLOTS)-1:0] io_rd_slot_in,
    input  wire logic [7:0]             io_rd_byte_in,
    output logic      [7:0]             io_rd_data_out,
    output logic                        io_rd_valid_out
);
    localparam int AW        = $clog2(`PPM_WIN_REGS);
    localparam int BW        = AW + 1;
    localparam int SW        = $clog2(SLOTS);
    localparam int WIN_BYTES = 2 * `PPM_WIN_REGS;

    // Table holds two entries per slot in 128 registers
    if (SLOTS < 2 || SLOTS > 64 || (1 << SW) != SLOTS) begin : g_bad
        $error("ppm_process_image_map: SLOTS must be a power of two from 2 to 64");
    end

    function automatic logic [7:0] in_bytes(input ppm_class_t c);
        case (c)
            PPM_CLS_DI8:  return 8'd1;
            PPM_CLS_DI16: return 8'd2;
            PPM_CLS_DITS: return 8'd60;
            PPM_CLS_AI4:  return 8'd8;
            PPM_CLS_AI8:  return 8'd16;
            PPM_CLS_CNT1: return 8'd12;
            PPM_CLS_CNT2: return 8'd12;
            PPM_CLS_FREQ: return 8'd20;
            PPM_CLS_PWM:  return 8'd4;
            PPM_CLS_SAFE: return 8'd4;
            default:      return 8'd0;
        endcase
    endfunction

    function automatic logic [7:0] out_bytes(input ppm_class_t c);
        case (c)
            PPM_CLS_DO8:  return 8'd1;
            PPM_CLS_DO16: return 8'd2;
            PPM_CLS_AO4:  return 8'd8;
            PPM_CLS_CNT1: return 8'd10;
            PPM_CLS_CNT2: return 8'd12;
            PPM_CLS_FREQ: return 8'd12;
            PPM_CLS_PWM:  return 8'd12;
            default:      return 8'd0;
        endcase
    endfunction

    // Entry: register index in the low bits, bit 15 set when starting in the high byte
    function automatic logic [15:0] ofs_entry(input logic [BW:0] start, input logic fit);
        logic [15:0] e;
        e = 16'(start[BW-1:1]);
        e[`PPM_OFS_HI_BIT] = start[0];
        return fit ? e : `PPM_OFS_NONE;
    endfunction

    function automatic logic [BW-1:0] entry_byte(input logic [15:0] e);
        return {e[AW-1:0], e[`PPM_OFS_HI_BIT]};
    endfunction

    ppm_state_t        st_q;
    logic [SW:0]       slot_q;
    logic [BW:0]       icur_q;
    logic [BW:0]       ocur_q;
    logic [7:0]        irem_q;
    logic [7:0]        orem_q;
    logic [WIN_BYTES-1:0] iocc_q;
    logic [WIN_BYTES-1:0] oocc_q;
    logic [15:0]       itab_q [SLOTS];
    logic [15:0]       otab_q [SLOTS];
    ppm_class_t        cls_q  [SLOTS];

    // Slot placement, worked out when the walker loads the next slot
    ppm_class_t  cur_cls;
    logic [7:0]  isz;
    logic [7:0]  osz;
    logic [BW:0] istart;
    logic [BW:0] ostart;
    logic [BW+1:0] iend;
    logic [BW+1:0] oend;
    logic        ifit;
    logic        ofit;
    logic        load;
    logic        restart;

    assign cur_cls = ppm_class_t'(cfg_class_in[slot_q[SW-1:0]*4 +: 4]);
    assign isz     = in_bytes(cur_cls);
    assign osz     = out_bytes(cur_cls);
    assign istart  = icur_q + {{BW{1'b0}}, (isz > 8'd1) & icur_q[0]};
    assign ostart  = ocur_q + {{BW{1'b0}}, (osz > 8'd1) & ocur_q[0]};
    assign iend    = {1'b0, istart} + (BW+2)'(isz);
    assign oend    = {1'b0, ostart} + (BW+2)'(osz);
    // A module that no longer fits is left unmapped rather than wrapped
    assign ifit    = (isz != 8'd0) && (iend <= (BW+2)'(WIN_BYTES));
    assign ofit    = (osz != 8'd0) && (oend <= (BW+2)'(WIN_BYTES));
    assign load    = (st_q == PPM_ST_WALK) && (irem_q == 8'd0) && (orem_q == 8'd0)
                     && (slot_q != (SW+1)'(SLOTS));
    assign restart = (st_q == PPM_ST_DONE) && cfg_load_in;
    assign map_busy_out = (st_q == PPM_ST_WALK);

    // Walker: one slot load or one byte per window each cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q   <= PPM_ST_WALK;
            slot_q <= '0;
            icur_q <= '0;
            ocur_q <= '0;
            irem_q <= 8'd0;
            orem_q <= 8'd0;
        end else begin
            case (st_q)
                PPM_ST_WALK: begin
                    if (load) begin
                        slot_q <= slot_q + (SW+1)'(1);
                        if (ifit) begin
                            icur_q <= istart;
                            irem_q <= isz;
                        end
                        if (ofit) begin
                            ocur_q <= ostart;
                            orem_q <= osz;
                        end
                    end else if (irem_q == 8'd0 && orem_q == 8'd0) begin
                        st_q <= PPM_ST_DONE;
                    end else begin
                        if (irem_q != 8'd0) begin
                            icur_q <= icur_q + (BW+1)'(1);
                            irem_q <= irem_q - 8'd1;
                        end
                        if (orem_q != 8'd0) begin
                            ocur_q <= ocur_q + (BW+1)'(1);
                            orem_q <= orem_q - 8'd1;
                        end
                    end
                end
                PPM_ST_DONE: begin
                    if (cfg_load_in) begin
                        st_q   <= PPM_ST_WALK;
                        slot_q <= '0;
                        icur_q <= '0;
                        ocur_q <= '0;
                    end
                end
                default: st_q <= PPM_ST_DONE;
            endcase
        end
    end

    // Byte occupancy decides what reads back as data and what takes writes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            iocc_q <= '0;
            oocc_q <= '0;
        end else if (restart) begin
            iocc_q <= '0;
            oocc_q <= '0;
        end else if (st_q == PPM_ST_WALK && !load) begin
            if (irem_q != 8'd0) begin
                iocc_q[icur_q[BW-1:0]] <= 1'b1;
            end
            if (orem_q != 8'd0) begin
                oocc_q[ocur_q[BW-1:0]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int s = 0; s < SLOTS; s++) begin
                itab_q[s] <= `PPM_OFS_NONE;
                otab_q[s] <= `PPM_OFS_NONE;
                cls_q[s]  <= PPM_CLS_NONE;
            end
        end else if (load) begin
            itab_q[slot_q[SW-1:0]] <= ofs_entry(istart, ifit);
            otab_q[slot_q[SW-1:0]] <= ofs_entry(ostart, ofit);
            cls_q[slot_q[SW-1:0]]  <= cur_cls;
        end
    end

    // Master access decode
    logic          in_hit;
    logic          out_hit;
    logic          tab_hit;
    logic [AW-1:0] widx;
    logic [1:0]    iocc_pair;
    logic [1:0]    oocc_pair;
    logic [15:0]   tab_val;
    logic [5:0]    tab_slot;
    logic          out_a_en;
    logic [1:0]    out_a_we;
    logic [15:0]   out_a_rdata;
    logic [15:0]   in_b_rdata;

    // Input base is zero, so only the upper limit is compared
    assign in_hit    = (reg_addr_in <= `PPM_IN_LAST);
    assign out_hit   = (reg_addr_in >= `PPM_OUT_BASE) && (reg_addr_in <= `PPM_OUT_LAST);
    assign tab_hit   = (reg_addr_in >= `PPM_OFS_BASE) && (reg_addr_in <= `PPM_OFS_LAST);
    assign widx      = reg_addr_in[AW-1:0];
    assign iocc_pair = {iocc_q[{widx, 1'b1}], iocc_q[{widx, 1'b0}]};
    assign oocc_pair = {oocc_q[{widx, 1'b1}], oocc_q[{widx, 1'b0}]};
    assign tab_slot  = reg_addr_in[6:1];
    assign tab_val   = ({1'b0, tab_slot} >= 7'(SLOTS)) ? `PPM_OFS_NONE :
                       (reg_addr_in[0] ? otab_q[tab_slot[SW-1:0]] : itab_q[tab_slot[SW-1:0]]);
    assign out_a_en  = reg_req_in && out_hit;
    assign out_a_we  = reg_we_in ? oocc_pair : 2'b00;

    logic        p1_vld_q;
    logic        p1_err_q;
    logic [1:0]  p1_src_q;
    logic [1:0]  p1_mask_q;
    logic [15:0] p1_tab_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            p1_vld_q  <= 1'b0;
            p1_err_q  <= 1'b0;
            p1_src_q  <= 2'd0;
            p1_mask_q <= 2'b00;
            p1_tab_q  <= `PPM_RDATA_RST;
        end else begin
            p1_vld_q  <= reg_req_in;
            p1_tab_q  <= tab_val;
            if (in_hit) begin
                p1_src_q  <= 2'd1;
                p1_mask_q <= iocc_pair;
                p1_err_q  <= reg_we_in;
            end else if (out_hit) begin
                p1_src_q  <= 2'd2;
                p1_mask_q <= oocc_pair;
                p1_err_q  <= 1'b0;
            end else if (tab_hit) begin
                p1_src_q  <= 2'd3;
                p1_mask_q <= 2'b11;
                p1_err_q  <= reg_we_in;
            end else begin
                p1_src_q  <= 2'd0;
                p1_mask_q <= 2'b00;
                p1_err_q  <= 1'b1;
            end
        end
    end

    logic [15:0] p1_data;
    logic [15:0] p1_bmask;

    assign p1_bmask = {{8{p1_mask_q[1]}}, {8{p1_mask_q[0]}}};
    assign p1_data  = (p1_src_q == 2'd1) ? in_b_rdata  :
                      (p1_src_q == 2'd2) ? out_a_rdata :
                      (p1_src_q == 2'd3) ? p1_tab_q    : `PPM_RDATA_RST;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_ack_out   <= 1'b0;
            reg_err_out   <= 1'b0;
            reg_rdata_out <= `PPM_RDATA_RST;
        end else begin
            reg_ack_out   <= p1_vld_q;
            reg_err_out   <= p1_vld_q && p1_err_q;
            reg_rdata_out <= p1_vld_q ? (p1_data & p1_bmask) : `PPM_RDATA_RST;
        end
    end

    // Backplane side: slot and byte index become a packed byte address
    logic [BW-1:0] io_wba;
    logic [BW-1:0] io_rba;
    logic          io_wok;
    logic          io_rok;

    assign io_wba = entry_byte(itab_q[io_wr_slot_in]) + BW'(io_wr_byte_in);
    assign io_rba = entry_byte(otab_q[io_rd_slot_in]) + BW'(io_rd_byte_in);
    assign io_wok = io_wr_in && (itab_q[io_wr_slot_in] != `PPM_OFS_NONE)
                    && (io_wr_byte_in < in_bytes(cls_q[io_wr_slot_in])) && iocc_q[io_wba];
    assign io_rok = (otab_q[io_rd_slot_in] != `PPM_OFS_NONE)
                    && (io_rd_byte_in < out_bytes(cls_q[io_rd_slot_in])) && oocc_q[io_rba];

    logic        r1_vld_q;
    logic        r1_ok_q;
    logic        r1_hi_q;
    logic [15:0] out_b_rdata;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r1_vld_q        <= 1'b0;
            r1_ok_q         <= 1'b0;
            r1_hi_q         <= 1'b0;
            io_rd_valid_out <= 1'b0;
            io_rd_data_out  <= `PPM_BYTE_RST;
        end else begin
            r1_vld_q        <= io_rd_in;
            r1_ok_q         <= io_rok;
            r1_hi_q         <= io_rba[0];
            io_rd_valid_out <= r1_vld_q;
            io_rd_data_out  <= !r1_ok_q ? `PPM_BYTE_RST :
                               (r1_hi_q ? out_b_rdata[15:8] : out_b_rdata[7:0]);
        end
    end

    ppm_image_ram #(.DEPTH(`PPM_WIN_REGS), .WIDTH(16)) u_in_img (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .a_en_in     (io_wok),
        .a_we_in     (io_wba[0] ? 2'b10 : 2'b01),
        .a_addr_in   (io_wba[BW-1:1]),
        .a_wdata_in  ({io_wr_data_in, io_wr_data_in}),
        .a_rdata_out (),
        .b_en_in     (reg_req_in && in_hit && !reg_we_in),
        .b_addr_in   (widx),
        .b_rdata_out (in_b_rdata)
    );

    ppm_image_ram #(.DEPTH(`PPM_WIN_REGS), .WIDTH(16)) u_out_img (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .a_en_in     (out_a_en),
        .a_we_in     (out_a_we),
        .a_addr_in   (widx),
        .a_wdata_in  (reg_wdata_in),
        .a_rdata_out (out_a_rdata),
        .b_en_in     (io_rd_in),
        .b_addr_in   (io_rba[BW-1:1]),
        .b_rdata_out (out_b_rdata)
    );

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_ack_latency: assert property (reg_req_in |-> ##2 reg_ack_out)
        else $error("register access not answered two cycles later");
    a_in_unused_zero: assert property (
        (reg_req_in && !reg_we_in && in_hit && iocc_pair == 2'b00) |-> ##2 (reg_rdata_out == 16'h0))
        else $error("unoccupied input register read nonzero");
    a_out_write_drop: assert property (
        (reg_req_in && reg_we_in && out_hit && oocc_pair == 2'b00) |-> (out_a_we == 2'b00))
        else $error("write to unbacked output register reached memory");
    a_in_window_ok: assert property (
        (reg_req_in && !reg_we_in && reg_addr_in <= 16'h01ff) |-> ##2 (reg_ack_out && !reg_err_out))
        else $error("input window read flagged as error");
    a_out_window_ok: assert property (
        (reg_req_in && reg_addr_in >= 16'h0800 && reg_addr_in <= 16'h09ff) |-> ##2 !reg_err_out)
        else $error("output window access flagged as error");
    a_table_read: assert property (
        (reg_req_in && !reg_we_in && tab_hit) |-> ##2 (!reg_err_out && reg_rdata_out == $past(tab_val, 2)))
        else $error("offset table read returned wrong value");
    a_word_align: assert property ((load && ifit && isz > 8'd1) |-> !istart[0])
        else $error("word data placed on odd byte");
    a_byte_pack: assert property ((load && isz == 8'd1) |-> (istart == icur_q))
        else $error("one-byte module did not take next free byte");
    a_slot_order: assert property (load |=> (icur_q >= $past(icur_q) && slot_q == $past(slot_q) + 1))
        else $error("slots not placed in order");

    c_walk_done:   cover property (st_q == PPM_ST_WALK ##1 st_q == PPM_ST_DONE);
    c_byte_pair:   cover property (load && isz == 8'd1 && icur_q[0]);
    c_out_write:   cover property (reg_req_in && reg_we_in && out_hit && oocc_pair == 2'b11);
    c_table_read:  cover property (reg_req_in && !reg_we_in && tab_hit);
endmodule
`default_nettype wire

// ==== sim/ppm_master_model.sv ====
// Register master model: one access at a time on the master port
// Assumes each request is answered by one ack pulse within a few cycles
`default_nettype none
module ppm_master_model (
    input  wire logic        ref_clk_in,
    output logic             reg_req_out,
    output logic             reg_we_out,
    output logic [15:0]      reg_addr_out,
    output logic [15:0]      reg_wdata_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        reg_ack_in,
    input  wire logic        reg_err_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_req_out = 1'b0;
        reg_we_out = 1'b0;
        reg_addr_out = 16'h0000;
        reg_wdata_out = 16'h0000;
    end
    // Register read or single write; ok is low if no answer came
    task automatic access(input logic we, input logic [15:0] addr, input logic [15:0] wd,
                          output logic [15:0] rd, output logic err, output logic ok);
        int n;
        @(posedge ref_clk_in);
        #1;
        reg_req_out = 1'b1;
        reg_we_out = we;
        reg_addr_out = addr;
        reg_wdata_out = wd;
        @(posedge ref_clk_in);
        #1;
        reg_req_out = 1'b0;
        // Released lines show no stale value
        reg_we_out = ~we;
        reg_addr_out = ~addr;
        reg_wdata_out = ~wd;
        ok = 1'b0;
        rd = 16'h0000;
        err = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (reg_ack_in === 1'b1) begin
                ok = 1'b1;
                rd = reg_rdata_in;
                err = reg_err_in;
            end else begin
                @(posedge ref_clk_in);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== sim/ppm_process_image_map_test.sv ====
// Self-checking bench for the packed process image map, four slots
// Assumes the master model drives the register port, the bench the backplane
`default_nettype none
module ppm_process_image_map_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ppm_pkg::*;
    localparam logic [15:0] CFG1 = {PPM_CLS_AO4, PPM_CLS_DI16, PPM_CLS_DI8, PPM_CLS_DI8};
    localparam logic [15:0] CFG2 = {PPM_CLS_DO8, PPM_CLS_DI8, PPM_CLS_DI16, PPM_CLS_DI8};
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cfg_load_in = 1'b0;
    logic [15:0] cfg_class_in = CFG1;
    logic        map_busy_out;
    logic        req, we, ack, err;
    logic [15:0] addr, wdata, rdata;
    logic        io_wr_in = 1'b0;
    logic        io_rd_in = 1'b0;
    logic [1:0]  io_wr_slot_in = 2'd0;
    logic [1:0]  io_rd_slot_in = 2'd0;
    logic [7:0]  io_wr_byte_in = 8'h00;
    logic [7:0]  io_wr_data_in = 8'h00;
    logic [7:0]  io_rd_byte_in = 8'h00;
    logic [7:0]  io_rd_data_out;
    logic        io_rd_valid_out;
    int          error_cnt = 0;
    int          comparisons = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    ppm_process_image_map #(.SLOTS(4)) i_ppm_process_image_map (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_load_in(cfg_load_in),
        .cfg_class_in(cfg_class_in), .map_busy_out(map_busy_out), .reg_req_in(req),
        .reg_we_in(we), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_ack_out(ack), .reg_err_out(err), .io_wr_in(io_wr_in),
        .io_wr_slot_in(io_wr_slot_in), .io_wr_byte_in(io_wr_byte_in),
        .io_wr_data_in(io_wr_data_in), .io_rd_in(io_rd_in), .io_rd_slot_in(io_rd_slot_in),
        .io_rd_byte_in(io_rd_byte_in), .io_rd_data_out(io_rd_data_out),
        .io_rd_valid_out(io_rd_valid_out));
    ppm_master_model i_ppm_master_model (
        .ref_clk_in(ref_clk_in), .reg_req_out(req), .reg_we_out(we), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_ack_in(ack), .reg_err_in(err));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] exp, input logic exp_err);
        logic [15:0] rd;
        logic e, ok;
        i_ppm_master_model.access(w, a, d, rd, e, ok);
        cmp({15'h0000, ok}, 16'h0001, "answer present");
        cmp({15'h0000, e}, {15'h0000, exp_err}, "error flag");
        if (!w) cmp(rd, exp, "read data");
    endtask
    task automatic load(input logic [15:0] cfg);
        int n;
        cfg_class_in = cfg;
        cfg_load_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        cfg_load_in = 1'b0;
        for (n = 0; n < 300 && map_busy_out !== 1'b0; n++) @(posedge ref_clk_in);
        #1;
        cmp({15'h0000, map_busy_out}, 16'h0000, "walk finished");
    endtask
    task automatic bp_wr(input logic [1:0] s, input logic [7:0] b, input logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        io_wr_in = 1'b1;
        io_wr_slot_in = s;
        io_wr_byte_in = b;
        io_wr_data_in = d;
        @(posedge ref_clk_in);
        #1;
        io_wr_in = 1'b0;
        io_wr_data_in = ~d;
    endtask
    task automatic bp_rd(input logic [1:0] s, input logic [7:0] b, input logic [7:0] exp);
        int n;
        @(posedge ref_clk_in);
        #1;
        io_rd_in = 1'b1;
        io_rd_slot_in = s;
        io_rd_byte_in = b;
        @(posedge ref_clk_in);
        #1;
        io_rd_in = 1'b0;
        for (n = 0; n < 4 && io_rd_valid_out !== 1'b1; n++) #8;
        cmp({15'h0000, io_rd_valid_out}, 16'h0001, "backplane valid");
        cmp({8'h00, io_rd_data_out}, {8'h00, exp}, "backplane byte");
    endtask
    task automatic t_input_window;
        bp_wr(2'd0, 8'h00, 8'h11);
        bp_wr(2'd1, 8'h00, 8'h22);
        bp_wr(2'd2, 8'h00, 8'h33);
        bp_wr(2'd2, 8'h01, 8'h44);
        for (int i = 0; i < 512; i++)
            acc(1'b0, 16'(i), 16'h0000, i == 0 ? 16'h2211 : i == 1 ? 16'h4433 : 16'h0000, 1'b0);
    endtask
    task automatic t_output_window;
        for (int i = 0; i < 5; i++) acc(1'b1, 16'h0800 + 16'(i), 16'ha5a0 + 16'(i), 16'h0000, 1'b0);
        for (int i = 0; i < 512; i++)
            acc(1'b0, 16'h0800 + 16'(i), 16'h0000, i < 4 ? 16'ha5a0 + 16'(i) : 16'h0000, 1'b0);
        bp_rd(2'd3, 8'h02, 8'ha1);
        bp_rd(2'd3, 8'h07, 8'ha5);
    endtask
    task automatic t_offsets;
        acc(1'b0, 16'h2b00, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, 16'h2b01, 16'h0000, 16'hffff, 1'b0);
        acc(1'b0, 16'h2b02, 16'h0000, 16'h8000, 1'b0);
        acc(1'b0, 16'h2b04, 16'h0000, 16'h0001, 1'b0);
        acc(1'b0, 16'h2b07, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, 16'h2b7f, 16'h0000, 16'hffff, 1'b0);
    endtask
    task automatic t_refusals;
        acc(1'b1, 16'h0000, 16'hffff, 16'h0000, 1'b1);
        acc(1'b1, 16'h2b00, 16'h1234, 16'h0000, 1'b1);
        acc(1'b0, 16'h0000, 16'h0000, 16'h2211, 1'b0);
        acc(1'b0, 16'h0400, 16'h0000, 16'h0000, 1'b1);
        acc(1'b0, 16'h0a00, 16'h0000, 16'h0000, 1'b1);
    endtask
    task automatic t_gap;
        load(CFG2);
        bp_wr(2'd0, 8'h00, 8'h5a);
        bp_wr(2'd1, 8'h00, 8'h6b);
        bp_wr(2'd1, 8'h01, 8'h7c);
        bp_wr(2'd2, 8'h00, 8'h8d);
        acc(1'b0, 16'h0000, 16'h0000, 16'h005a, 1'b0);
        acc(1'b0, 16'h0001, 16'h0000, 16'h7c6b, 1'b0);
        acc(1'b0, 16'h0002, 16'h0000, 16'h008d, 1'b0);
        acc(1'b0, 16'h2b02, 16'h0000, 16'h0001, 1'b0);
        acc(1'b1, 16'h0800, 16'habcd, 16'h0000, 1'b0);
        acc(1'b1, 16'h0801, 16'h1234, 16'h0000, 1'b0);
        acc(1'b0, 16'h0800, 16'h0000, 16'h00cd, 1'b0);
        acc(1'b0, 16'h0801, 16'h0000, 16'h0000, 1'b0);
        bp_rd(2'd3, 8'h00, 8'hcd);
        bp_rd(2'd3, 8'h01, 8'h00);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        $display("ERROR at %0t: run did not finish", $time);
        test_done();
    end
    initial begin
        repeat (10) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        for (int n = 0; n < 300 && map_busy_out !== 1'b0; n++) @(posedge ref_clk_in);
        t_input_window();
        t_output_window();
        t_offsets();
        t_refusals();
        t_gap();
        test_done();
    end
endmodule
`default_nettype wire
